// file: hw/sac_pkg.sv
package sac_pkg;

    // ------------------------------------------------------------
    // converter geometry and result word layout
    // ------------------------------------------------------------
    localparam int SAC_BITS = 12;
    localparam int SAC_RES_LSB = 16;
    localparam int SAC_SIGN_LSB = 28;
    localparam logic [11:0] SAC_MIDSCALE = 12'h800;
    localparam logic [3:0] SAC_MSB_IDX = 4'hB;

    // ------------------------------------------------------------
    // sequencer timing, in converter clocks
    // ------------------------------------------------------------
    localparam int SAC_EXTRA_CLKS = 19;
    localparam logic [4:0] SAC_TAIL_CLKS = 5'(SAC_EXTRA_CLKS - SAC_BITS);
    localparam logic [2:0] SAC_DIV_RST = 3'h1;
    localparam logic [1:0] SAC_ACQ_RST = 2'h2;
    // throughput target at the fastest converter clock
    localparam real SAC_MCLK_MHZ = 250.0;
    localparam real SAC_TARGET_KSPS = 1000.0;
    localparam int SAC_MAX_CONV_CYC = int'(SAC_MCLK_MHZ * 1000.0 / SAC_TARGET_KSPS);

    // ------------------------------------------------------------
    // input multiplexer
    // ------------------------------------------------------------
    localparam int SAC_MUX_W = 5;
    localparam logic [4:0] SAC_TEMP_CHAN = 5'h10;

    // ------------------------------------------------------------
    // trigger sources
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SAC_TRIG_SW = 3'h0,
        SAC_TRIG_PIN = 3'h1,
        SAC_TRIG_PLA = 3'h2,
        SAC_TRIG_TMR0 = 3'h3,
        SAC_TRIG_TMR1 = 3'h4
    } sac_trig_e;

    typedef enum logic [1:0] {
        SAC_IDLE = 2'h0,
        SAC_ACQ = 2'h1,
        SAC_CONV = 2'h2,
        SAC_TAIL = 2'h3
    } sac_state_e;

    typedef struct packed {
        sac_state_e st;
        logic [4:0] div_cnt;
        logic [4:0] cnt;
        logic [2:0] div_sel;
        logic [1:0] acq_sel;
        logic diff;
        logic trig_prev;
        logic [31:0] data;
        logic valid;
        logic [4:0] mux;
    } sac_top_s;

    typedef struct packed {
        logic [11:0] code;
        logic [3:0] idx;
    } sac_sar_s;

endpackage

// file: hw/sac_sar_if.sv
`timescale 1ns/10ps
interface sac_sar_if;
    logic load;
    logic step;
    logic comp;
    logic [11:0] code;
    logic last;

    modport ctl (output load, output step, output comp, input code, input last);
    modport eng (input load, input step, input comp, output code, output last);
endinterface

// file: hw/sac_sar_step.sv
`timescale 1ns/10ps
module sac_sar_step (
    input wire logic mclk,
    input wire logic resetn,
    sac_sar_if.eng sar
);

    sac_pkg::sac_sar_s s_q, s_d;

    // ------------------------------------------------------------
    // one bit trial per step, msb first
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (sar.load) begin
            s_d.code = sac_pkg::SAC_MIDSCALE;
            s_d.idx = sac_pkg::SAC_MSB_IDX;
        end else if (sar.step) begin
            // comparator low means the trial weight overshot the input
            s_d.code[s_q.idx] = sar.comp; // see RULE1
            if (s_q.idx != 4'h0) begin
                s_d.code[s_q.idx - 4'h1] = 1'b1;
                s_d.idx = s_q.idx - 4'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sar.code = s_q.code;
    assign sar.last = (s_q.idx == 4'h0);

endmodule

// file: hw/sac_top.sv
`timescale 1ns/10ps
// What this block does
// RULE1: twelve bit successive approximation, msb first
// RULE2: single-ended or differential mode, software selected
// RULE3: software single or continuous conversions
// RULE4: one selected hardware trigger source repeats conversions
// RULE5: temperature channel selectable on input multiplexer
// RULE6: single-ended results are straight binary
// RULE7: one million conversions per second at fastest
// RULE8: differential results are twos complement
// RULE9: result in bits 16-27, sign above
// RULE10: reset defaults: eight acquisition clocks, divide two
// RULE11: continuous mode restarts acquisition after each write
module sac_top #(
    parameter int CHAN_W = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic conv_enable,
    input wire logic single_start,
    input wire logic continuous_mode,
    input wire logic [2:0] trig_sel,
    input wire logic ext_conversion_trigger_pin,
    input wire logic programmable_logic_array,
    input wire logic first_general_timer,
    input wire logic second_general_timer,
    input wire logic diff_mode,
    input wire logic [CHAN_W-1:0] chan_sel,
    input wire logic temp_chan_sel,
    input wire logic [2:0] clk_div_sel,
    input wire logic [1:0] acq_sel,
    input wire logic comp_in,
    output logic [4:0] mux_sel,
    output logic track,
    output logic [11:0] dac_code,
    output logic [31:0] result_data,
    output logic result_valid,
    output logic busy
);

    sac_pkg::sac_top_s s_q, s_d;
    sac_sar_if sar ();
    logic trig_lvl;
    logic start;
    logic tick;

    sac_sar_step u_sar (
        .mclk(mclk),
        .resetn(resetn),
        .sar(sar)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] div_last(input logic [2:0] sel);
        // selector codes above five fall back to the slowest divide
        div_last = (sel > 3'h5) ? 5'h1F : 5'((6'h1 << sel) - 6'h1);
    endfunction

    function automatic logic [4:0] acq_last(input logic [1:0] sel);
        acq_last = 5'((6'h2 << sel) - 6'h1);
    endfunction

    function automatic logic [31:0] pack_result(input logic [11:0] code, input logic diff);
        logic [11:0] v;
        v = diff ? (code ^ sac_pkg::SAC_MIDSCALE) : code; // see RULE8 see RULE6
        pack_result = '0;
        pack_result[sac_pkg::SAC_RES_LSB +: sac_pkg::SAC_BITS] = v; // see RULE9
        pack_result[31:sac_pkg::SAC_SIGN_LSB] = (diff && v[11]) ? 4'hF : 4'h0; // see RULE9
    endfunction

    // ------------------------------------------------------------
    // trigger selection
    // ------------------------------------------------------------
    always_comb begin
        case (sac_pkg::sac_trig_e'(trig_sel)) // see RULE4
            sac_pkg::SAC_TRIG_PIN: trig_lvl = ext_conversion_trigger_pin;
            sac_pkg::SAC_TRIG_PLA: trig_lvl = programmable_logic_array;
            sac_pkg::SAC_TRIG_TMR0: trig_lvl = first_general_timer;
            sac_pkg::SAC_TRIG_TMR1: trig_lvl = second_general_timer;
            default: trig_lvl = 1'b0;
        endcase
    end

    // hardware triggers act on rising edges; software starts only in software mode
    assign start = conv_enable && (
        (trig_sel == 3'(sac_pkg::SAC_TRIG_SW) && (single_start || continuous_mode)) // see RULE3
        || (trig_lvl && !s_q.trig_prev)); // see RULE4
    assign tick = (s_q.div_cnt == div_last(s_q.div_sel));

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.valid = 1'b0;
        s_d.trig_prev = trig_lvl;
        s_d.div_cnt = (s_q.st == sac_pkg::SAC_IDLE || tick) ? 5'h0 : s_q.div_cnt + 5'h1;
        sar.load = 1'b0;
        sar.step = 1'b0;
        sar.comp = comp_in;
        case (s_q.st)
            sac_pkg::SAC_IDLE: begin
                if (start) begin
                    // settings are caught at start so a conversion never sees them change
                    s_d.div_sel = clk_div_sel;
                    s_d.acq_sel = acq_sel;
                    s_d.diff = diff_mode; // see RULE2
                    s_d.mux = temp_chan_sel ? sac_pkg::SAC_TEMP_CHAN
                        : 5'(chan_sel); // see RULE5
                    s_d.cnt = acq_last(acq_sel);
                    s_d.st = sac_pkg::SAC_ACQ;
                end
            end
            sac_pkg::SAC_ACQ: begin
                if (tick) begin
                    if (s_q.cnt == 5'h0) begin
                        sar.load = 1'b1; // see RULE1
                        s_d.st = sac_pkg::SAC_CONV;
                    end else begin
                        s_d.cnt = s_q.cnt - 5'h1;
                    end
                end
            end
            sac_pkg::SAC_CONV: begin
                if (tick) begin
                    sar.step = 1'b1; // see RULE1
                    if (sar.last) begin
                        s_d.cnt = sac_pkg::SAC_TAIL_CLKS - 5'h1;
                        s_d.st = sac_pkg::SAC_TAIL;
                    end
                end
            end
            sac_pkg::SAC_TAIL: begin
                if (tick) begin
                    if (s_q.cnt == 5'h0) begin
                        s_d.data = pack_result(sar.code, s_q.diff);
                        s_d.valid = 1'b1;
                        // with divide one and eight acquisition clocks this path gives 27 cycles, far under the 1 us budget
                        if (conv_enable && continuous_mode
                            && trig_sel == 3'(sac_pkg::SAC_TRIG_SW)) begin // see RULE11 see RULE7
                            s_d.cnt = acq_last(s_q.acq_sel);
                            s_d.st = sac_pkg::SAC_ACQ;
                        end else begin
                            s_d.st = sac_pkg::SAC_IDLE;
                        end
                    end else begin
                        s_d.cnt = s_q.cnt - 5'h1;
                    end
                end
            end
            default: s_d.st = sac_pkg::SAC_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.div_sel <= sac_pkg::SAC_DIV_RST; // see RULE10
            s_q.acq_sel <= sac_pkg::SAC_ACQ_RST; // see RULE10
        end else begin
            s_q <= s_d;
        end
    end

    assign mux_sel = s_q.mux;
    assign track = (s_q.st == sac_pkg::SAC_ACQ);
    assign dac_code = sar.code;
    assign result_data = s_q.data;
    assign result_valid = s_q.valid;
    assign busy = (s_q.st != sac_pkg::SAC_IDLE);

endmodule

// file: tb/sac_analog_model.sv
`timescale 1ns/10ps
module sac_analog_model (
    input wire logic [4:0] mux_sel,
    input wire logic [11:0] dac_code,
    input wire logic track,
    output logic comp_in
);
    logic [11:0] level;
    // each input sits at its own level so a result shows which one was routed
    assign level = {mux_sel, 7'h2B};
    // comparator means nothing while sampling, so it just gives the inverted dac_code lsb then
    assign comp_in = track ? ~dac_code[0] : (level >= dac_code);
endmodule

// file: tb/sac_top_sva.sv
`timescale 1ns/10ps
module sac_top_sva #(
    parameter int CHAN_W = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic conv_enable,
    input wire logic single_start,
    input wire logic continuous_mode,
    input wire logic [2:0] trig_sel,
    input wire logic diff_mode,
    input wire logic [CHAN_W-1:0] chan_sel,
    input wire logic temp_chan_sel,
    input wire logic [2:0] clk_div_sel,
    input wire logic [4:0] mux_sel,
    input wire logic track,
    input wire logic [11:0] dac_code,
    input wire logic [31:0] result_data,
    input wire logic result_valid,
    input wire logic busy
);
    // the two fastest clock divides must finish within 249 cycles, just inside one microsecond
    localparam int MAXC = 249;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------
    // sequencer checks
    // ------------------------------------------------------------
    chk_valid_pulse: assert property (result_valid |=> !result_valid)
        else $error("result_valid held too long");
    chk_sw_take: assert property (!busy && conv_enable && trig_sel == 3'h0 && single_start
        |=> busy && track) else $error("software start not taken");
    chk_msb_trial: assert property ($fell(track) && busy |-> dac_code == 12'h800)
        else $error("first trial not midscale");
    chk_mux_latch: assert property ($rose(busy) |-> mux_sel ==
        ($past(temp_chan_sel) ? 5'h10 : 5'($past(chan_sel)))) else $error("mux_sel wrong");
    chk_rate_bound: assert property ($rose(busy) && $past(clk_div_sel) <= 3'h1
        |-> ##[0:MAXC] result_valid) else $error("conversion too slow");
    chk_cont_restart: assert property (result_valid && continuous_mode && conv_enable
        && trig_sel == 3'h0 |=> busy && track) else $error("no continuous restart");
    chk_word_layout: assert property (result_valid |-> result_data[15:0] == 16'h0000)
        else $error("low half not zero");
    chk_straight_bin: assert property (result_valid && !diff_mode
        |-> result_data[31:28] == 4'h0) else $error("single-ended sign set");
    chk_diff_sign: assert property (result_valid && diff_mode
        |-> result_data[31:28] == {4{result_data[27]}}) else $error("sign bits wrong");
endmodule
bind sac_top sac_top_sva #(.CHAN_W(CHAN_W)) sac_top_sva_inst (.mclk(mclk), .resetn(resetn),
    .conv_enable(conv_enable), .single_start(single_start), .continuous_mode(continuous_mode),
    .trig_sel(trig_sel), .diff_mode(diff_mode), .chan_sel(chan_sel),
    .temp_chan_sel(temp_chan_sel), .clk_div_sel(clk_div_sel), .mux_sel(mux_sel),
    .track(track), .dac_code(dac_code), .result_data(result_data),
    .result_valid(result_valid), .busy(busy));

// file: tb/tb_sar_adc_conversion_control.sv
`timescale 1ns/10ps
module tb_sar_adc_conversion_control;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic en = 1'b0, ss = 1'b0, cm = 1'b0, dm = 1'b0, tmp = 1'b0;
    logic [2:0] ts = 3'h0, dv = 3'h1;
    logic [1:0] aq = 2'h2;
    logic [3:0] ch = 4'h0, trg = 4'h0;
    logic comp, vld, busy, track;
    logic [4:0] mux;
    logic [11:0] dac;
    logic [31:0] dat;
    int fails = 0, samples_checked = 0, cyc = 0;
    always #2 mclk = ~mclk;
    sac_top sac_top_inst (.mclk(mclk), .resetn(resetn), .conv_enable(en), .single_start(ss),
        .continuous_mode(cm), .trig_sel(ts), .ext_conversion_trigger_pin(trg[0]),
        .programmable_logic_array(trg[1]), .first_general_timer(trg[2]),
        .second_general_timer(trg[3]), .diff_mode(dm), .chan_sel(ch), .temp_chan_sel(tmp),
        .clk_div_sel(dv), .acq_sel(aq), .comp_in(comp), .mux_sel(mux), .track(track),
        .dac_code(dac), .result_data(dat), .result_valid(vld), .busy(busy));
    sac_analog_model sac_analog_model_inst (.mux_sel(mux), .dac_code(dac), .track(track),
        .comp_in(comp));
    task automatic finish_test();
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            finish_test();
        end
    end
    task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cmp_int(input string n, input int e, input int g);
        samples_checked++;
        if (g != e) begin
            fails++;
            $display("[ERR] %s exp %0d got %0d", n, e, g);
        end
    endtask
    // expected word from the level the analog model puts on the routed input
    task automatic await(input int lat);
        int n;
        logic [11:0] c;
        n = 0;
        c = tmp ? 12'h82B : {1'b0, ch, 7'h2B};
        c = dm ? c ^ 12'h800 : c;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (vld !== 1'b1 && n < 400);
        cmp_word("result_valid", 32'h1, 32'(vld));
        if (lat > 0) cmp_int("latency", lat, n);
        cmp_word("result_data", {{4{dm & c[11]}}, c, 16'h0000}, dat);
    endtask
    task automatic sw_conv(input logic [3:0] c, input logic d, input logic t, input int lat);
        ch = c;
        dm = d;
        tmp = t;
        ss = 1'b1;
        @(posedge mclk);
        #1;
        ss = 1'b0;
        await(lat);
        @(posedge mclk);
        #1;
    endtask
    task automatic t_modes();
        // (8 acquisition + 19 extra) converter clocks at divide two
        sw_conv(4'hF, 1'b0, 1'b0, 54);
        sw_conv(4'h3, 1'b1, 1'b0, 54);
        sw_conv(4'h0, 1'b1, 1'b1, 54);
        dv = 3'h0;
        aq = 2'h0;
        // (2 acquisition + 19 extra) converter clocks at divide one
        sw_conv(4'hA, 1'b0, 1'b0, 21);
    endtask
    // wrong source and a software start must both be ignored in hardware mode
    task automatic t_trig();
        for (int s = 1; s <= 4; s++) begin
            ts = 3'(s);
            ss = 1'b1;
            trg[s % 4] = 1'b1;
            repeat (3) @(posedge mclk);
            #1;
            cmp_word("busy", 32'h0, 32'(busy));
            ss = 1'b0;
            trg = 4'h0;
            @(posedge mclk);
            #1;
            trg[s - 1] = 1'b1;
            @(posedge mclk);
            #1;
            await(21);
            trg = 4'h0;
            @(posedge mclk);
            #1;
        end
        ts = 3'h0;
    endtask
    task automatic t_cont();
        ch = 4'h5;
        cm = 1'b1;
        @(posedge mclk);
        #1;
        await(21);
        await(0);
        await(0);
        en = 1'b0;
        cm = 1'b0;
        repeat (40) @(posedge mclk);
        #1;
        cmp_word("busy", 32'h0, 32'(busy));
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        #1;
        resetn = 1'b1;
        en = 1'b1;
        t_modes();
        t_trig();
        t_cont();
        finish_test();
    end
endmodule
